//--- pkg/smme_map.svh
/*
 * Bit positions, reset values and timing counts for the serial master
 * engine. Assumes it is included by the package and the engine files.
 */
`ifndef SMME_MAP_SVH
`define SMME_MAP_SVH

// ----------------------------------------------------------------------
// Control register bit positions
// ----------------------------------------------------------------------
`define SMME_CTL_IFEN_BIT   0
`define SMME_CTL_SELLO_BIT  2
`define SMME_CTL_SELHI_BIT  3
`define SMME_CTL_MODE_FAULT_FLAG_BIT   5
`define SMME_CTL_MASTER_ENABLE_BIT_BIT  6
`define SMME_CTL_DONE_BIT   7

// ----------------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------------
`define SMME_CTL_RESET      8'h04
`define SMME_CLK_PERIOD_NS  8
`define SMME_SCK_HALF_NS    64
`define SMME_SCK_HALF_CYC   (`SMME_SCK_HALF_NS / `SMME_CLK_PERIOD_NS)

`endif

//--- pkg/smme_pkg.sv
/*
 * Types shared by the serial master engine files.
 * Assumes the map header sits beside it on the include path.
 */
package smme_pkg;
	`include "smme_map.svh"

	typedef enum logic [1:0] {
		SMME_ST_IDLE  = 2'b00,
		SMME_ST_LOW   = 2'b01,
		SMME_ST_HIGH  = 2'b10
	} smme_state_t;

	// Processor side write strobe and data byte group.
	typedef struct packed {
		logic       wr;
		logic [7:0] data;
	} smme_wr_t;
endpackage

//--- verilog/smme_sync.sv
/*
 * Three-stage input synchroniser with agreement filter.
 * Assumes the input is asynchronous to clk_sys.
 */
`timescale 1ns/1ps
module smme_sync
	import smme_pkg::*;
#(
	parameter logic RESET_VAL = 1'b0
) (
	// Clock and reset
	input  wire logic clk_sys,
	input  wire logic resetn,
	// Data
	input  wire logic din,
	output logic      dout
);
	logic [2:0] sh_reg;
	logic [2:0] sh_next;
	logic       out_reg;
	logic       out_next;

	always_comb begin
		sh_next  = {sh_reg[1:0], din};
		out_next = out_reg;
		// The first stage feeds only the second; only stages 2 and 3 agree.
		if (sh_reg[2] == sh_reg[1]) begin
			out_next = sh_reg[2];
		end
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			sh_reg  <= {3{RESET_VAL}};
			out_reg <= RESET_VAL;
		end else begin
			sh_reg  <= sh_next;
			out_reg <= out_next;
		end
	end

	assign dout = out_reg;
endmodule

//--- verilog/smme_engine.sv
/*
 * Serial master engine: transmit buffer, shift register, clock
 * generation, receive buffer and slave-select mode handling.
 * Assumes a processor drives the write strobes on clk_sys and
 * that miso and the select pin arrive asynchronously.
 */
//
// Overview of operation
// - Master operation runs while the master enable bit (bit 6) is set.
// - A data write in master operation lands in the transmit buffer.
// - With the shifter empty and the interface enable (bit 0) set, the buffered byte loads and a transfer starts.
// - Transfer shifts data out on mosi while the engine drives sck.
// - End of each byte sets the complete flag, bit 7.
// - Interrupt request rises when complete flag sets and interrupts enabled.
// - Incoming byte is captured most significant bit first.
// - Full received byte moves to receive buffer; data read returns it.
// - Select bits 3=0, 2=1 give multi-master mode; select pin is input.
// - Low select in multi-master clears enables and sets mode fault, bit 5.
// - Mode fault raises an interrupt request when interrupts enabled.
// - Both select bits 0 leaves the select pin unused and undriven.
// - Select bit 3 set drives the select pin as an output.
// - In 4-wire mode the select output follows select bit 2.
`timescale 1ns/1ps
`include "smme_map.svh"
module smme_engine
	import smme_pkg::*;
#(
	parameter int HALF_CYC = `SMME_SCK_HALF_CYC
) (
	// Clock and reset
	input  wire logic       clk_sys,
	input  wire logic       resetn,
	// Control register access
	input  wire logic       ctl_wr,
	input  wire logic [7:0] ctl_wdata,
	output logic      [7:0] ctl_rdata,
	// Data register access
	input  wire smme_wr_t   dat_wr,
	output logic      [7:0] dat_rdata,
	// Interrupt enable and request
	input  wire logic       irq_en,
	output logic            irq,
	// Serial pins
	output logic            sck,
	output logic            mosi,
	input  wire logic       miso,
	input  wire logic       sel_in,
	output logic            sel_out,
	output logic            sel_oe
);
	localparam logic [7:0] HALF = 8'(HALF_CYC);

	logic        miso_s;
	logic        sel_s;
	smme_state_t st_reg, st_next;
	logic [7:0]  ctl_reg, ctl_next;
	logic [7:0]  txb_reg, txb_next;
	logic        txv_reg, txv_next;
	logic [7:0]  sh_reg, sh_next;
	logic [7:0]  rxb_reg, rxb_next;
	logic [2:0]  bit_reg, bit_next;
	logic [7:0]  div_reg, div_next;
	logic        sck_reg, sck_next;
	logic        mosi_reg, mosi_next;
	logic        irq_reg, irq_next;
	logic        so_reg, so_next;
	logic        soe_reg, soe_next;
	logic        done_ev, fault_ev;

	// ------------------------------------------------------------------
	// Input synchronisers
	// ------------------------------------------------------------------
	smme_sync #(.RESET_VAL(1'b0)) u_miso (
		.clk_sys (clk_sys),
		.resetn  (resetn),
		.din     (miso),
		.dout    (miso_s)
	);
	smme_sync #(.RESET_VAL(1'b1)) u_sel (
		.clk_sys (clk_sys),
		.resetn  (resetn),
		.din     (sel_in),
		.dout    (sel_s)
	);

	// ------------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------------
	always_comb begin
		st_next   = st_reg;
		ctl_next  = ctl_reg;
		txb_next  = txb_reg;
		txv_next  = txv_reg;
		sh_next   = sh_reg;
		rxb_next  = rxb_reg;
		bit_next  = bit_reg;
		div_next  = div_reg;
		sck_next  = 1'b0;
		mosi_next = mosi_reg;
		done_ev   = 1'b0;
		fault_ev  = 1'b0;

		if (ctl_wr) begin
			// A done or fault event in this cycle still wins over the write.
			ctl_next = ctl_wdata;
		end
		if (dat_wr.wr && ctl_reg[`SMME_CTL_MASTER_ENABLE_BIT_BIT]) begin
			txb_next = dat_wr.data;
			txv_next = 1'b1;
		end

		case (st_reg)
			SMME_ST_IDLE: begin
				if (txv_reg && ctl_reg[`SMME_CTL_MASTER_ENABLE_BIT_BIT]
					&& ctl_reg[`SMME_CTL_IFEN_BIT]) begin
					sh_next   = txb_reg;
					mosi_next = txb_reg[7];
					txv_next  = dat_wr.wr;
					bit_next  = 3'd0;
					div_next  = 8'd0;
					st_next   = SMME_ST_LOW;
				end
			end
			SMME_ST_LOW: begin
				sck_next = div_reg == HALF - 8'd1;
				div_next = div_reg + 8'd1;
				if (div_reg == HALF - 8'd1) begin
					div_next = 8'd0;
					st_next  = SMME_ST_HIGH;
					sh_next  = {sh_reg[6:0], miso_s};
				end
			end
			SMME_ST_HIGH: begin
				sck_next = 1'b1;
				div_next = div_reg + 8'd1;
				if (div_reg == HALF - 8'd1) begin
					sck_next = 1'b0;
					div_next = 8'd0;
					mosi_next = sh_reg[7];
					bit_next = bit_reg + 3'd1;
					st_next  = SMME_ST_LOW;
					if (bit_reg == 3'd7) begin
						rxb_next = sh_reg;
						done_ev  = 1'b1;
						st_next  = SMME_ST_IDLE;
					end
				end
			end
			default: st_next = SMME_ST_IDLE;
		endcase

		// Multi-master: select pulled low drops the master out.
		if (!ctl_reg[`SMME_CTL_SELHI_BIT] && ctl_reg[`SMME_CTL_SELLO_BIT]
			&& !sel_s) begin
			fault_ev = 1'b1;
			ctl_next[`SMME_CTL_MASTER_ENABLE_BIT_BIT] = 1'b0;
			ctl_next[`SMME_CTL_IFEN_BIT]  = 1'b0;
			st_next  = SMME_ST_IDLE;
			sck_next = 1'b0;
		end
		if (done_ev) begin
			ctl_next[`SMME_CTL_DONE_BIT] = 1'b1;
		end
		if (fault_ev) begin
			ctl_next[`SMME_CTL_MODE_FAULT_FLAG_BIT] = 1'b1;
		end

		irq_next = irq_en && (ctl_next[`SMME_CTL_DONE_BIT]
			|| ctl_next[`SMME_CTL_MODE_FAULT_FLAG_BIT]);
		so_next  = ctl_next[`SMME_CTL_SELLO_BIT];
		soe_next = ctl_next[`SMME_CTL_SELHI_BIT];
	end

	// ------------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			st_reg   <= SMME_ST_IDLE;
			ctl_reg  <= `SMME_CTL_RESET;
			txb_reg  <= 8'h00;
			txv_reg  <= 1'b0;
			sh_reg   <= 8'h00;
			rxb_reg  <= 8'h00;
			bit_reg  <= 3'd0;
			div_reg  <= 8'h00;
			sck_reg  <= 1'b0;
			mosi_reg <= 1'b0;
			irq_reg  <= 1'b0;
			so_reg   <= 1'b1;
			soe_reg  <= 1'b0;
		end else begin
			st_reg   <= st_next;
			ctl_reg  <= ctl_next;
			txb_reg  <= txb_next;
			txv_reg  <= txv_next;
			sh_reg   <= sh_next;
			rxb_reg  <= rxb_next;
			bit_reg  <= bit_next;
			div_reg  <= div_next;
			sck_reg  <= sck_next;
			mosi_reg <= mosi_next;
			irq_reg  <= irq_next;
			so_reg   <= so_next;
			soe_reg  <= soe_next;
		end
	end

	assign ctl_rdata = ctl_reg;
	assign dat_rdata = rxb_reg;
	assign irq       = irq_reg;
	assign sck       = sck_reg;
	assign mosi      = mosi_reg;
	assign sel_out   = so_reg;
	assign sel_oe    = soe_reg;
endmodule

//--- test/smme_properties.sv
/* Port assertions for the serial master engine.
   Assumes the default sck half period of eight clocks. */
`timescale 1ns/1ps
module smme_checker
	import smme_pkg::*;
#(
	parameter int HALF_CYC = 8
) (
	// Clock and reset
	input wire logic       clk_sys,
	input wire logic       resetn,
	// Processor side
	input wire logic       ctl_wr,
	input wire logic [7:0] ctl_wdata,
	input wire logic [7:0] ctl_rdata,
	input wire smme_wr_t   dat_wr,
	input wire logic [7:0] dat_rdata,
	input wire logic       irq_en,
	input wire logic       irq,
	// Serial pins
	input wire logic       sck,
	input wire logic       mosi,
	input wire logic       miso,
	input wire logic       sel_in,
	input wire logic       sel_out,
	input wire logic       sel_oe
);
	logic       sck_reg;
	logic [7:0] rx_reg;
	logic [7:0] rx_next;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!resetn);
	// Raw miso is stable around each sck rise, so it mirrors the byte.
	always_comb begin
		rx_next = (sck && !sck_reg) ? {rx_reg[6:0], miso} : rx_reg;
	end
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			sck_reg <= 1'b0;
			rx_reg <= 8'h00;
		end else begin
			sck_reg <= sck;
			rx_reg <= rx_next;
		end
	end
	AST_DONE_IRQ: assert property ($rose(ctl_rdata[7]) && irq_en |-> ##[0:1] irq)
		else $error("no irq after done");
	AST_DONE_END: assert property ($rose(ctl_rdata[7]) |-> !sck && $past(sck, 2))
		else $error("done off the last sck fall");
	AST_RX_BYTE: assert property ($rose(ctl_rdata[7]) |-> ##[0:1] dat_rdata == rx_reg)
		else $error("received byte wrong");
	AST_SCK_HIGH: assert property ($rose(sck) |-> sck [*8] ##1 !sck)
		else $error("sck high phase wrong");
	AST_IDLE: assert property (!ctl_rdata[6] && !sck |=> !sck)
		else $error("sck without master");
	AST_SEL_DRIVE: assert property ((ctl_rdata[3]) [*2] |-> sel_oe)
		else $error("select not driven");
	AST_SEL_LEVEL: assert property (ctl_rdata[3] && $stable(ctl_rdata[3:2])
		|-> sel_out == ctl_rdata[2])
		else $error("select level wrong");
	AST_FAULT: assert property ((ctl_rdata[3:2] == 2'b01 && !sel_in) [*8]
		|-> ctl_rdata[5] && !ctl_rdata[6] && !ctl_rdata[0])
		else $error("mode fault missed");
endmodule
bind smme_engine smme_checker #(.HALF_CYC(HALF_CYC)) u_chk (
	.clk_sys(clk_sys), .resetn(resetn), .ctl_wr(ctl_wr),
	.ctl_wdata(ctl_wdata), .ctl_rdata(ctl_rdata), .dat_wr(dat_wr),
	.dat_rdata(dat_rdata), .irq_en(irq_en), .irq(irq), .sck(sck),
	.mosi(mosi), .miso(miso), .sel_in(sel_in), .sel_out(sel_out),
	.sel_oe(sel_oe));

//--- test/smme_slave_model.sv
/* Serial slave answering two bytes MSB first.
   Assumes sck idles low; data moves on its falling edge. */
`timescale 1ns/1ps
module smme_slave_model (
	// Serial pins
	input  wire logic        sck,
	input  wire logic        mosi,
	output logic             miso,
	// Bench side
	input  wire logic [15:0] tx,
	output logic      [15:0] rx
);
	int j = 0;
	int k = 0;
	// Past the last bit the inverse shows, so stale data never passes.
	assign miso = (k < 16) ? tx[15 - k] : ~tx[0];
	always @(posedge sck) begin
		rx <= {rx[14:0], mosi};
		j <= j + 1;
	end
	always @(negedge sck) k <= j;
endmodule

//--- test/smme_tb_top.sv
/* Self-checking bench for the serial master engine.
   Assumes the default sck half period of eight clocks. */
`timescale 1ns/1ps
module smme_tb_top
	import smme_pkg::*;
;
	logic clk_sys, resetn, ctl_wr, irq_en, irq, sck, mosi, miso;
	logic sel_in, sel_out, sel_oe;
	logic [7:0] ctl_wdata, ctl_rdata, dat_rdata;
	logic [15:0] rx;
	smme_wr_t dat_wr;
	int miscompares = 0;
	int checks_done = 0;
	smme_engine dut (.clk_sys(clk_sys), .resetn(resetn), .ctl_wr(ctl_wr),
		.ctl_wdata(ctl_wdata), .ctl_rdata(ctl_rdata), .dat_wr(dat_wr),
		.dat_rdata(dat_rdata), .irq_en(irq_en), .irq(irq), .sck(sck),
		.mosi(mosi), .miso(miso), .sel_in(sel_in), .sel_out(sel_out),
		.sel_oe(sel_oe));
	smme_slave_model slave (.sck(sck), .mosi(mosi), .miso(miso),
		.tx(16'h5AC3), .rx(rx));
	task automatic chk(logic [7:0] seen, logic [7:0] exp);
		checks_done++;
		if (seen !== exp) begin
			miscompares++;
			$display("unexpected at %0t: got %h want %h", $time, seen, exp);
		end
	endtask
	task automatic wctl(logic [7:0] v);
		@(negedge clk_sys) ctl_wr = 1'b1;
		ctl_wdata = v;
		@(negedge clk_sys) ctl_wr = 1'b0;
	endtask
	task automatic wdat(logic [7:0] v);
		@(negedge clk_sys) dat_wr = '{wr: 1'b1, data: v};
		@(negedge clk_sys) dat_wr.wr = 1'b0;
	endtask
	task automatic wait_done;
		for (int n = 0; n < 400 && ctl_rdata[7] !== 1'b1; n++) begin
			@(negedge clk_sys);
		end
		chk({7'h00, ctl_rdata[7]}, 8'h01);
	endtask
	task automatic conclude;
		$display("checks %0d, miscompares %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	initial begin
		clk_sys = 1'b0;
		forever #4 clk_sys = ~clk_sys;
	end
	initial begin
		#200000;
		miscompares++;
		conclude();
	end
	initial begin
		resetn = 1'b0;
		ctl_wr = 1'b0;
		ctl_wdata = 8'h00;
		dat_wr = '{wr: 1'b0, data: 8'h00};
		irq_en = 1'b1;
		sel_in = 1'b1;
		repeat (10) @(negedge clk_sys);
		resetn = 1'b1;
		chk(ctl_rdata, 8'h04);
		chk({5'h00, irq, sel_oe, sel_out}, 8'h01);
		wctl(8'h05);
		wdat(8'hFF);
		repeat (40) @(negedge clk_sys);
		chk(ctl_rdata, 8'h05);
		wctl(8'h45);
		wdat(8'hA5);
		wdat(8'h3C);
		wait_done();
		chk(ctl_rdata, 8'hC5);
		chk(dat_rdata, 8'h5A);
		chk({7'h00, irq}, 8'h01);
		wctl(8'h45);
		wait_done();
		chk(dat_rdata, 8'hC3);
		chk(rx[15:8], 8'hA5);
		chk(rx[7:0], 8'h3C);
		wctl(8'h4D);
		@(negedge clk_sys);
		chk({5'h00, irq, sel_oe, sel_out}, 8'h03);
		wctl(8'h49);
		@(negedge clk_sys);
		chk({5'h00, irq, sel_oe, sel_out}, 8'h02);
		wctl(8'h41);
		@(negedge clk_sys);
		chk({7'h00, sel_oe}, 8'h00);
		wctl(8'h45);
		sel_in = 1'b0;
		repeat (10) @(negedge clk_sys);
		chk(ctl_rdata, 8'h24);
		chk({7'h00, irq}, 8'h01);
		irq_en = 1'b0;
		repeat (2) @(negedge clk_sys);
		chk({7'h00, irq}, 8'h00);
		irq_en = 1'b1;
		sel_in = 1'b1;
		repeat (10) @(negedge clk_sys);
		wctl(8'h45);
		chk(ctl_rdata, 8'h45);
		conclude();
	end
endmodule
